/* File: hdl/pgp_top.sv */
// Contract
// - Baud change answers 0x61 first at old rate, then switches.
// - Link rate defaults to 19200 unless a saved rate exists.
// - New rate survives power-up only after store; then starts at stored rate. Code: reset clears the stored rate to 19200; only a reload applies it.
// - Five user pins, shared with power control and sensor functions.
// - Output can be constant low, constant high or 100 Hz PWM.
// - Pins sampled continuously at 32 Hz; latest level kept for queries.
// - Rising and falling edges since last query recorded per pin.
// - Only periodic samples are seen; glitches between them vanish.
// - Output byte 0 low, 1-99 duty percent, 100 high; above invalid.
// - Config byte optional, 0-15; bit 3 function, bits 2-0 drive.
// - Drive modes 000 to 011 as pull-down, strong, hi-Z, pull-up.
// - Drive modes 100 to 111 slow variants; 110 reserved.
// - Function 1 follows user output; 0 uses default role, drive kept.
// - Accepted pin set answers with 0x62, no data.
// - Pin configuration is part of the stored boot state.
// - Read reports the sampled actual pin level.
// - Read returns requested output level exactly as stored.
// - Read returns function and drive in set layout, upper bits zero.
`default_nettype none
module pgp_top #(
  parameter int NUM_PINS = pgp_pkg::NUM_PINS,
  parameter int PWM_STEP_CYCLES = pgp_pkg::PWM_STEP_CYCLES,
  parameter int SAMPLE_CYCLES = pgp_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] alt_level_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_out,
  output logic [NUM_PINS-1:0] pin_pull_up_out,
  output logic [NUM_PINS-1:0] pin_pull_dn_out,
  output logic [NUM_PINS-1:0] pin_slow_out,
  output logic [31:0] baud_rate_out
);
  logic [7:0] duty [NUM_PINS];
  pgp_pkg::pgp_cfg_t cfg [NUM_PINS];
  logic [7:0] boot_duty [NUM_PINS];
  pgp_pkg::pgp_cfg_t boot_cfg [NUM_PINS];
  logic [31:0] boot_baud;
  logic [31:0] pending_baud;
  logic baud_pending;
  logic [7:0] reply_type;
  logic reply_valid;
  logic reply_reject;
  logic [31:0] result;
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] sampled;
  logic [NUM_PINS-1:0] rise_seen;
  logic [NUM_PINS-1:0] fall_seen;
  logic [31:0] sample_cnt;
  logic sample_tick;
  logic sample_primed;
  logic [31:0] step_cnt;
  logic [6:0] phase;
  logic [31:0] sample_gap;

  function automatic pgp_pkg::pgp_cfg_t factory_cfg(input int idx);
    // Pin 1 senses host power through a pull-up; the others rest as inputs
    return (idx == 1) ? pgp_pkg::CFG_DEFAULT_SENSE : pgp_pkg::CFG_DEFAULT_HIZ;
  endfunction

  logic accept;
  logic wr_ok;
  logic [7:0] set_idx;
  logic [7:0] set_out;
  logic [7:0] set_cfg_raw;
  logic set_cfg_present;
  logic set_valid;
  logic do_set;
  logic set_bad;
  logic do_query;
  logic [7:0] query_idx;
  logic do_baud;
  logic do_store;
  logic do_reload;
  logic reply_read;

  assign accept = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  assign wr_ok = accept && avs_write_in && (avs_byteenable_in == 4'hF);
  assign set_idx = avs_writedata_in[pgp_pkg::SET_IDX_LSB +: 8];
  assign set_out = avs_writedata_in[pgp_pkg::SET_OUT_LSB +: 8];
  assign set_cfg_raw = avs_writedata_in[pgp_pkg::SET_CFG_LSB +: 8];
  assign set_cfg_present = avs_writedata_in[pgp_pkg::SET_CFG_PRESENT];
  assign set_valid = (set_idx < 8'(NUM_PINS))
    && (set_out <= pgp_pkg::DUTY_HIGH)
    && !(set_cfg_present && set_cfg_raw[7:4] != 4'h0);
  assign do_set = wr_ok && avs_address_in == pgp_pkg::OFS_SET && set_valid;
  assign set_bad = wr_ok && avs_address_in == pgp_pkg::OFS_SET && !set_valid;
  assign query_idx = avs_writedata_in[7:0];
  assign do_query = wr_ok && avs_address_in == pgp_pkg::OFS_QUERY
    && query_idx < 8'(NUM_PINS);
  assign do_baud = wr_ok && avs_address_in == pgp_pkg::OFS_BAUD && avs_writedata_in != 32'h0;
  assign do_store = wr_ok && avs_address_in == pgp_pkg::OFS_BOOT
    && avs_writedata_in[pgp_pkg::BOOT_STORE];
  assign do_reload = wr_ok && avs_address_in == pgp_pkg::OFS_BOOT
    && avs_writedata_in[pgp_pkg::BOOT_RELOAD];
  assign reply_read = accept && avs_read_in && avs_address_in == pgp_pkg::OFS_REPLY;

  // One wait cycle per access keeps read data a plain register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      case (avs_address_in)
        pgp_pkg::OFS_RESULT: avs_readdata_out <= result;
        pgp_pkg::OFS_BAUD: avs_readdata_out <= baud_rate_out;
        pgp_pkg::OFS_REPLY: avs_readdata_out <= {22'h0, reply_reject, reply_valid, reply_type};
        default: avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // Live pin settings and their stored copies
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_cfg
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        duty[i] <= 8'h00;
        cfg[i] <= factory_cfg(i);
      end else if (do_reload) begin
        duty[i] <= boot_duty[i];
        cfg[i] <= boot_cfg[i];
      end else if (do_set && set_idx == 8'(i)) begin
        duty[i] <= set_out;
        if (set_cfg_present) begin
          cfg[i] <= pgp_pkg::pgp_cfg_t'(set_cfg_raw[3:0]);
        end
      end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        boot_duty[i] <= 8'h00;
        boot_cfg[i] <= factory_cfg(i);
      end else if (do_store) begin
        boot_duty[i] <= duty[i];
        boot_cfg[i] <= cfg[i];
      end
    end
  end

  // Baud: old rate holds until the acknowledge has been collected
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      baud_rate_out <= pgp_pkg::BAUD_DEFAULT;
      pending_baud <= pgp_pkg::BAUD_DEFAULT;
      baud_pending <= 1'b0;
    end else if (do_baud) begin
      pending_baud <= avs_writedata_in;
      baud_pending <= 1'b1;
    end else if (reply_read && baud_pending) begin
      baud_rate_out <= pending_baud;
      baud_pending <= 1'b0;
    end else if (do_reload) begin
      baud_rate_out <= boot_baud;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_baud <= pgp_pkg::BAUD_DEFAULT;
    end else if (do_store) begin
      boot_baud <= baud_rate_out;
    end
  end

  // New reply beats the read that collects the old one
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reply_type <= 8'h00;
      reply_valid <= 1'b0;
      reply_reject <= 1'b0;
    end else if (do_baud) begin
      reply_type <= pgp_pkg::REPLY_BAUD;
      reply_valid <= 1'b1;
      reply_reject <= 1'b0;
    end else if (do_set) begin
      reply_type <= pgp_pkg::REPLY_SET;
      reply_valid <= 1'b1;
      reply_reject <= 1'b0;
    end else if (set_bad) begin
      reply_type <= pgp_pkg::REPLY_SET;
      reply_valid <= 1'b1;
      reply_reject <= 1'b1;
    end else if (reply_read) begin
      reply_valid <= 1'b0;
    end
  end

  // Query snapshot: level and edges, request and config as stored
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result <= 32'h0;
    end else if (do_query) begin
      result <= {4'h0, 4'(cfg[query_idx[2:0]]),
                 duty[query_idx[2:0]],
                 5'h00, fall_seen[query_idx[2:0]], rise_seen[query_idx[2:0]],
                 sampled[query_idx[2:0]],
                 query_idx};
    end
  end

  // Shared timebases for PWM phase and input sampling
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      step_cnt <= 32'h0;
      phase <= 7'h00;
    end else if (step_cnt == 32'(PWM_STEP_CYCLES - 1)) begin
      step_cnt <= 32'h0;
      phase <= (phase == 7'(pgp_pkg::PWM_STEPS - 1)) ? 7'h00 : phase + 7'h01;
    end else begin
      step_cnt <= step_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_cnt <= 32'h0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (sample_cnt == 32'(SAMPLE_CYCLES - 1));
      sample_cnt <= (sample_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : sample_cnt + 32'h1;
    end
  end

  // First tick only loads the samples, so reset never fakes an edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_primed <= 1'b0;
    end else if (sample_tick) begin
      sample_primed <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pgp_pkg::pgp_pad_t pad;

    // Only tick-time levels count, so short pulses are missed by design
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sampled[i] <= 1'b0;
      end else if (sample_tick) begin
        sampled[i] <= pin_sync[i];
      end
    end

    // An edge seen in the query cycle survives the clear
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        rise_seen[i] <= 1'b0;
        fall_seen[i] <= 1'b0;
      end else begin
        if (sample_tick && sample_primed && pin_sync[i] && !sampled[i]) begin
          rise_seen[i] <= 1'b1;
        end else if (do_query && query_idx == 8'(i)) begin
          rise_seen[i] <= 1'b0;
        end
        if (sample_tick && sample_primed && !pin_sync[i] && sampled[i]) begin
          fall_seen[i] <= 1'b1;
        end else if (do_query && query_idx == 8'(i)) begin
          fall_seen[i] <= 1'b0;
        end
      end
    end

    pgp_pin u_pin (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .duty_in(duty[i]),
      .cfg_in(cfg[i]),
      .alt_level_in(alt_level_in[i]),
      .phase_in(phase),
      .pad_out(pad)
    );

    assign pin_out[i] = pad.o;
    assign pin_oe_out[i] = pad.oe;
    assign pin_pull_up_out[i] = pad.pull_up;
    assign pin_pull_dn_out[i] = pad.pull_dn;
    assign pin_slow_out[i] = pad.slow;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_gap <= 32'h0;
    end else begin
      // Tick cycle counts as one, so a full period reads exactly SAMPLE_CYCLES
      sample_gap <= sample_tick ? 32'h1 : sample_gap + 32'h1;
    end
  end

  a_set_reply: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    do_set |=> (reply_valid && reply_type == pgp_pkg::REPLY_SET && !reply_reject))
    else $error("accepted set without 0x62 reply");
  a_baud_ack_first: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (do_baud && avs_writedata_in != baud_rate_out) |=> ($stable(baud_rate_out)
     && reply_type == pgp_pkg::REPLY_BAUD && reply_valid))
    else $error("rate switched before acknowledge");
  a_baud_switch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (reply_read && baud_pending) |=> (baud_rate_out == $past(pending_baud) && !reply_valid))
    else $error("rate not switched after acknowledge");
  a_bad_index: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_ok && avs_address_in == pgp_pkg::OFS_SET && set_idx >= 8'(NUM_PINS))
    |=> (reply_reject && reply_valid))
    else $error("out of range pin index accepted");
  a_sample_period: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    sample_gap <= 32'(SAMPLE_CYCLES))
    else $error("input sample interval too long");
  a_duty_range: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    do_set |=> (duty[$past(set_idx[2:0])] == $past(set_out)
     && duty[$past(set_idx[2:0])] <= pgp_pkg::DUTY_HIGH))
    else $error("stored duty above full scale");
  a_edge_rise: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (sample_tick && sample_primed && pin_sync[0] && !sampled[0]) |=> rise_seen[0])
    else $error("rising edge not recorded");
  a_wait_single: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

/* File: hdl/pgp_pkg.sv */
`default_nettype none
package pgp_pkg;
  localparam int NUM_PINS = 5;
  localparam int CLK_HZ = 25_000_000;
  localparam int PWM_FREQ_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int SAMPLE_FREQ_HZ = 32;
  localparam int PWM_STEP_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_FREQ_HZ;

  localparam logic [7:0] DUTY_HIGH = 8'h64;
  localparam logic [7:0] REPLY_BAUD = 8'h61;
  localparam logic [7:0] REPLY_SET = 8'h62;
  localparam logic [31:0] BAUD_DEFAULT = 32'h0000_4B00;

  localparam logic [4:0] OFS_SET = 5'h00;
  localparam logic [4:0] OFS_QUERY = 5'h04;
  localparam logic [4:0] OFS_RESULT = 5'h08;
  localparam logic [4:0] OFS_BAUD = 5'h0C;
  localparam logic [4:0] OFS_BOOT = 5'h10;
  localparam logic [4:0] OFS_REPLY = 5'h14;

  localparam int SET_IDX_LSB = 0;
  localparam int SET_OUT_LSB = 8;
  localparam int SET_CFG_LSB = 16;
  localparam int SET_CFG_PRESENT = 24;
  localparam int BOOT_STORE = 0;
  localparam int BOOT_RELOAD = 1;
  localparam int REPLY_VALID = 8;
  localparam int REPLY_REJECT = 9;

  typedef enum logic [2:0] {
    PGP_DRV_UP_PD = 3'b000,
    PGP_DRV_STRONG = 3'b001,
    PGP_DRV_HIZ = 3'b010,
    PGP_DRV_PU_DN = 3'b011,
    PGP_DRV_SLOW_UP = 3'b100,
    PGP_DRV_SLOW = 3'b101,
    PGP_DRV_RSVD = 3'b110,
    PGP_DRV_SLOW_DN = 3'b111
  } pgp_drive_t;

  typedef struct packed {
    logic func;
    pgp_drive_t drive_mode_field;
  } pgp_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic slow;
  } pgp_pad_t;

  localparam pgp_cfg_t CFG_DEFAULT_HIZ = '{func: 1'b0, drive_mode_field: PGP_DRV_HIZ};
  localparam pgp_cfg_t CFG_DEFAULT_SENSE = '{func: 1'b0, drive_mode_field: PGP_DRV_PU_DN};
endpackage
`default_nettype wire

/* File: hdl/pgp_pin.sv */
`default_nettype none
module pgp_pin (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] duty_in,
  input wire pgp_pkg::pgp_cfg_t cfg_in,
  input wire logic alt_level_in,
  input wire logic [6:0] phase_in,
  output pgp_pkg::pgp_pad_t pad_out
);
  function automatic pgp_pkg::pgp_pad_t drive(input logic lvl, input pgp_pkg::pgp_drive_t m);
    pgp_pkg::pgp_pad_t p;
    p = '0;
    case (m)
      pgp_pkg::PGP_DRV_UP_PD: begin
        p.oe = lvl;
        p.o = lvl;
        p.pull_dn = !lvl;
      end
      pgp_pkg::PGP_DRV_STRONG: begin
        p.oe = 1'b1;
        p.o = lvl;
      end
      pgp_pkg::PGP_DRV_PU_DN: begin
        p.oe = !lvl;
        p.pull_up = lvl;
      end
      pgp_pkg::PGP_DRV_SLOW_UP: begin
        p.oe = lvl;
        p.o = lvl;
        p.slow = 1'b1;
      end
      pgp_pkg::PGP_DRV_SLOW: begin
        p.oe = 1'b1;
        p.o = lvl;
        p.slow = 1'b1;
      end
      pgp_pkg::PGP_DRV_SLOW_DN: begin
        p.oe = !lvl;
        p.slow = 1'b1;
      end
      // Reserved code parks the pin, safest for unknown loads
      default: p = '0;
    endcase
    return p;
  endfunction

  logic level;
  // Phase runs 0..99, so duty 0 never rises and 100 never falls
  assign level = cfg_in.func ? ({1'b0, phase_in} < duty_in) : alt_level_in;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pad_out <= '0;
    end else begin
      pad_out <= drive(level, cfg_in.drive_mode_field);
    end
  end

  a_full_duty_high: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (cfg_in.func && duty_in == pgp_pkg::DUTY_HIGH
     && cfg_in.drive_mode_field == pgp_pkg::PGP_DRV_STRONG) |=> (pad_out.o && pad_out.oe))
    else $error("full duty pin not driven high");
  a_zero_duty_low: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (cfg_in.func && duty_in == 8'h00 && cfg_in.drive_mode_field == pgp_pkg::PGP_DRV_STRONG)
    |=> (!pad_out.o && pad_out.oe))
    else $error("zero duty pin not driven low");
  a_hiz_mode_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (cfg_in.drive_mode_field == pgp_pkg::PGP_DRV_HIZ) |=> (pad_out == '0))
    else $error("input mode pin is driven");
endmodule
`default_nettype wire

/* File: test/pgp_pad_load.sv */
`default_nettype none
module pgp_pad_load (
  input wire logic clk_in,
  input wire logic [4:0] pin_out_in,
  input wire logic [4:0] pin_oe_in,
  input wire logic [4:0] pull_up_in,
  input wire logic [4:0] pull_dn_in,
  input wire logic [4:0] ext_en_in,
  input wire logic [4:0] ext_level_in,
  output logic [4:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] flip = 5'h00;
  always_ff @(posedge clk_in) begin
    flip <= ~flip;
  end
  // Undriven pins toggle so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else if (ext_en_in[i]) begin
        level_out[i] = ext_level_in[i];
      end else if (pull_up_in[i]) begin
        level_out[i] = 1'b1;
      end else if (pull_dn_in[i]) begin
        level_out[i] = 1'b0;
      end else begin
        level_out[i] = flip[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/pgp_top_tb_top.sv */
`default_nettype none
module pgp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 2;
  localparam int SAMP = 8;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic [4:0] alt = 5'h00;
  logic [4:0] ext_en = 5'h00;
  logic [4:0] ext_lvl = 5'h00;
  logic [4:0] pin_lvl, p_o, p_oe, p_pu, p_pd, p_slow;
  logic [31:0] baud;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  initial forever #20 clk_in = ~clk_in;

  pgp_top #(.PWM_STEP_CYCLES(STEP), .SAMPLE_CYCLES(SAMP)) u_pgp_top (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .pin_in(pin_lvl),
    .alt_level_in(alt), .pin_out(p_o), .pin_oe_out(p_oe), .pin_pull_up_out(p_pu),
    .pin_pull_dn_out(p_pd), .pin_slow_out(p_slow), .baud_rate_out(baud));

  pgp_pad_load u_pgp_pad_load (
    .clk_in(clk_in), .pin_out_in(p_o), .pin_oe_in(p_oe), .pull_up_in(p_pu),
    .pull_dn_in(p_pd), .ext_en_in(ext_en), .ext_level_in(ext_lvl), .level_out(pin_lvl));

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    chk("edges to answer", 32'h2, 32'(n));
  endtask

  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 4'hF, q);
  endtask

  task automatic rd32(input logic [4:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0000_0000, 4'hF, q);
  endtask

  task automatic set_pin(input logic [7:0] i, input logic [7:0] o, input logic [7:0] c,
                         input logic [9:0] rep);
    logic [31:0] q;
    wr32(pgp_pkg::OFS_SET, {7'h00, 1'b1, c, o, i});
    rd32(pgp_pkg::OFS_REPLY, q);
    chk("reply", {22'h0, rep}, {22'h0, q[9:0]});
  endtask

  task automatic query(input logic [7:0] i, output logic [31:0] q);
    wr32(pgp_pkg::OFS_QUERY, {24'h00_0000, i});
    rd32(pgp_pkg::OFS_RESULT, q);
  endtask

  // Pad bits {o, oe, pull_up, pull_dn, slow}; o and slow only matter while driving
  function automatic logic [4:0] pad_exp(input logic [2:0] m, input logic lv);
    case ({m, lv})
      4'b0000: pad_exp = 5'b00010;
      4'b0001, 4'b0011: pad_exp = 5'b11000;
      4'b0010, 4'b0110: pad_exp = 5'b01000;
      4'b0111: pad_exp = 5'b00100;
      4'b1001, 4'b1011: pad_exp = 5'b11001;
      4'b1010, 4'b1110: pad_exp = 5'b01001;
      default: pad_exp = 5'b00000;
    endcase
  endfunction

  task automatic t_reset;
    logic [31:0] q;
    chk("baud at reset", 32'h0000_4B00, baud);
    query(8'h01, q);
    chk("pin1 cfg", {20'h0, 4'h3, 8'h00}, {20'h0, q[27:16]});
    query(8'h02, q);
    chk("pin2 cfg", {20'h0, 4'h2, 8'h00}, {20'h0, q[27:16]});
  endtask

  task automatic t_drive;
    logic [31:0] q;
    logic [7:0] o;
    for (int m = 0; m < 8; m++) begin
      for (int lv = 0; lv < 2; lv++) begin
        if (m == 6) continue;
        o = (lv == 1) ? 8'h64 : 8'h00;
        set_pin(8'h02, o, {5'h01, m[2:0]}, 10'h162);
        repeat (3) @(posedge clk_in);
        chk("pad", {27'h0, pad_exp(m[2:0], lv[0])}, {27'h0, p_oe[2] & p_o[2], p_oe[2],
            p_pu[2], p_pd[2], p_oe[2] & p_slow[2]});
        query(8'h02, q);
        chk("readback", {20'h0, 1'b1, m[2:0], o}, {20'h0, q[27:16]});
        chk("upper zero", 32'h0, {q[31:28], 28'h0});
      end
    end
  endtask

  task automatic t_pwm;
    logic [7:0] duty[3] = '{8'h01, 8'h32, 8'h63};
    int hi;
    for (int k = 0; k < 3; k++) begin
      set_pin(8'h03, duty[k], 8'h09, 10'h162);
      repeat (3) @(posedge clk_in);
      hi = 0;
      repeat (100 * STEP) begin
        @(posedge clk_in);
        hi += (p_o[3] === 1'b1) ? 1 : 0;
      end
      chk("pwm high cycles", 32'(duty[k]) * STEP, 32'(hi));
    end
  endtask

  task automatic t_func;
    logic [31:0] q;
    set_pin(8'h04, 8'h64, 8'h01, 10'h162);
    alt[4] <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("default role low", 32'h1, {30'h0, p_o[4], p_oe[4]});
    alt[4] <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("default role high", 32'h3, {30'h0, p_o[4], p_oe[4]});
    query(8'h04, q);
    chk("stored duty", 32'h64, {24'h0, q[23:16]});
  endtask

  task automatic t_sample;
    logic [31:0] q;
    set_pin(8'h00, 8'h64, 8'h09, 10'h162);
    repeat (3 * SAMP) @(posedge clk_in);
    query(8'h00, q);
    query(8'h00, q);
    chk("driven level", 32'h1, {29'h0, q[10:8]});
    ext_en[0] <= 1'b1;
    ext_lvl[0] <= 1'b0;
    set_pin(8'h00, 8'h64, 8'h0A, 10'h162);
    repeat (3 * SAMP) @(posedge clk_in);
    query(8'h00, q);
    chk("fall seen", 32'h4, {29'h0, q[10:8]});
    query(8'h00, q);
    chk("fall cleared", 32'h0, {29'h0, q[10:8]});
    ext_lvl[0] <= 1'b1;
    repeat (3 * SAMP) @(posedge clk_in);
    query(8'h00, q);
    chk("rise seen", 32'h3, {29'h0, q[10:8]});
  endtask

  task automatic t_reject;
    logic [31:0] q;
    set_pin(8'h05, 8'h00, 8'h09, 10'h362);
    set_pin(8'h02, 8'h65, 8'h09, 10'h362);
    set_pin(8'h02, 8'h00, 8'h10, 10'h362);
    bus(pgp_pkg::OFS_SET, 1'b1, 32'h0109_0002, 4'h3, q);
    query(8'h02, q);
    chk("pin2 kept", {20'h0, 4'hF, 8'h64}, {20'h0, q[27:16]});
    rd32(5'h18, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_baud;
    logic [31:0] q;
    wr32(pgp_pkg::OFS_BAUD, 32'h0000_2580);
    @(posedge clk_in);
    chk("old rate kept", 32'h0000_4B00, baud);
    rd32(pgp_pkg::OFS_REPLY, q);
    chk("baud ack", 32'h161, {22'h0, q[9:0]});
    repeat (2) @(posedge clk_in);
    chk("new rate", 32'h0000_2580, baud);
    wr32(pgp_pkg::OFS_BOOT, 32'h0000_0001);
    wr32(pgp_pkg::OFS_BAUD, 32'h0000_9600);
    rd32(pgp_pkg::OFS_REPLY, q);
    set_pin(8'h02, 8'h20, 8'h09, 10'h162);
    wr32(pgp_pkg::OFS_BOOT, 32'h0000_0002);
    repeat (2) @(posedge clk_in);
    chk("boot rate", 32'h0000_2580, baud);
    query(8'h02, q);
    chk("boot pin", {20'h0, 4'hF, 8'h64}, {20'h0, q[27:16]});
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // Pin 1 keeps its default role setting throughout
    t_reset();
    t_drive();
    t_pwm();
    t_func();
    t_sample();
    t_reject();
    t_baud();
    test_done();
  end
endmodule
`default_nettype wire
